// ===== hw/clk_gen.sv
module clk_gen (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// source and control
	input wire logic src_tick,
	input wire logic [1:0] divider,
	input wire logic off,
	// generated clock
	output logic clk_out
);
	typedef struct packed {
		logic [2:0] cnt;
		logic out;
	} gen_s;

	gen_s st_q;
	gen_s st_d;
	logic [2:0] lim;

	// half-ticks per output half period minus one: 1,2,4,8 division
	assign lim = 3'((4'h1 << divider) - 4'h1);

	always_comb begin
		st_d = st_q;
		if (off && !st_q.out) begin
			st_d.cnt = '0;
		end else if (src_tick) begin
			if (st_q.cnt >= lim) begin
				st_d.cnt = '0;
				st_d.out = !st_q.out;
			end else begin
				st_d.cnt = st_q.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign clk_out = st_q.out;

	property p_gate_low;
		@(posedge clk_sys) disable iff (!rst_n)
		off && !clk_out |=> !clk_out;
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("gated clock left low state");

	property p_edge_on_tick;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_out != $past(clk_out)) |-> $past(src_tick);
	endproperty
	a_edge_on_tick: assert property (p_edge_on_tick) else $error("clock edge without source tick");
endmodule

// ===== hw/dco_clock_control_modulator.sv
module dco_clock_control_modulator (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// power-up clear from the reset logic
	input wire logic power_up_clear,
	// crystal clock pins
	input wire logic low_freq_xtal_clock,
	input wire logic second_xtal_clock,
	// avalon-mm slave
	input wire dco_pkg::avs_req_s avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// analog control
	output logic dco_enable,
	output logic bias_generator_on,
	output logic [3:0] internal_resistor_value,
	output logic bias_from_external,
	// generated clocks
	output dco_pkg::sys_clocks_s clocks
);
	typedef struct packed {
		dco_pkg::dco_ctrl_s dco_ctrl;
		dco_pkg::res_ctrl_s res_ctrl;
		dco_pkg::clk_ctrl_s clk_ctrl;
		dco_pkg::lp_ctrl_s lp_ctrl;
		logic [1:0] lf_sync;
		logic [1:0] xt2_sync;
		logic lf_prev;
		logic xt2_prev;
		logic ack;
		logic [7:0] rdata;
		logic bias_generator_ready;
		logic [7:0] start_cnt;
		logic [5:0] per_cnt;
		logic [4:0] slot;
		logic dco_level;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic mclk_need;
	logic sub_main_clock_need;
	logic dco_run;
	logic use_high;
	logic dco_tick;
	logic lf_tick;
	logic xt2_tick;
	logic crystal_tick;
	logic mclk_tick;
	logic sub_main_clock_tick;
	logic [5:0] half_per;
	logic mclk_q;
	logic sub_main_clock_q;
	logic [7:0] rd_mux;
	dco_pkg::status_s status;

	function automatic logic [4:0] bit_rev5(input logic [4:0] v);
		bit_rev5 = {v[0], v[1], v[2], v[3], v[4]};
	endfunction

	// higher step shortens the half period; lower resistor select slows it
	function automatic logic [5:0] half_period(input logic [2:0] rsel, input logic [2:0] step);
		half_period = dco_pkg::HALF_PERIOD_BASE + {3'h0, ~rsel} + {3'h0, ~step};
	endfunction

	function automatic logic use_high_slot(input logic [4:0] slot, input logic [4:0] frac, input logic [2:0] step);
		use_high_slot = (frac != 5'h00) && (step != dco_pkg::STEP_MAX) && (bit_rev5(slot) < frac);
	endfunction

	// clock demand
	assign mclk_need = !st_q.lp_ctrl.mclk_off && !st_q.clk_ctrl.mclk_source_select[1];
	assign sub_main_clock_need = !st_q.lp_ctrl.sub_main_clock_off && !st_q.clk_ctrl.sub_main_clock_source_select;
	assign dco_enable = mclk_need || sub_main_clock_need;
	assign bias_generator_on = dco_enable || !st_q.lp_ctrl.dco_generator_off;
	assign internal_resistor_value = {st_q.res_ctrl.resistor_off, st_q.res_ctrl.resistor_select};
	assign bias_from_external = st_q.clk_ctrl.external_resistor_select;

	// oscillator runs only with bias current available and generator settled
	assign dco_run = dco_enable && st_q.bias_generator_ready &&
		(st_q.clk_ctrl.external_resistor_select || !st_q.res_ctrl.resistor_off);

	// per-cycle step choice, bit-reversed slot spreads the high slots
	assign use_high = use_high_slot(st_q.slot, st_q.dco_ctrl.fraction_count,
		st_q.dco_ctrl.freq_step_select);
	assign half_per = half_period(st_q.res_ctrl.resistor_select,
		st_q.dco_ctrl.freq_step_select + 3'(use_high));
	assign dco_tick = dco_run && (st_q.per_cnt >= half_per - 6'h01);

	assign lf_tick = st_q.lf_sync[1] ^ st_q.lf_prev;
	assign xt2_tick = st_q.xt2_sync[1] ^ st_q.xt2_prev;
	assign crystal_tick = dco_pkg::THREE_OSC ? xt2_tick : lf_tick;

	always_comb begin
		if (!st_q.clk_ctrl.mclk_source_select[1]) begin
			mclk_tick = dco_tick;
		end else if (st_q.clk_ctrl.mclk_source_select == dco_pkg::MSEL_XT2) begin
			mclk_tick = crystal_tick;
		end else begin
			mclk_tick = lf_tick;
		end
		sub_main_clock_tick = st_q.clk_ctrl.sub_main_clock_source_select ? crystal_tick : dco_tick;
	end

	assign status = '{use_high_step: use_high, sub_main_clock: sub_main_clock_q, mclk: mclk_q,
		bias_generator_ready: st_q.bias_generator_ready, bias_generator_on: bias_generator_on, dco_enable: dco_enable};

	always_comb begin
		if (avs_req.address == dco_pkg::ADDR_DCO_CTRL) begin
			rd_mux = st_q.dco_ctrl;
		end else if (avs_req.address == dco_pkg::ADDR_RES_CTRL) begin
			rd_mux = {4'h0, st_q.res_ctrl};
		end else if (avs_req.address == dco_pkg::ADDR_CLK_CTRL) begin
			rd_mux = st_q.clk_ctrl;
		end else if (avs_req.address == dco_pkg::ADDR_LP_CTRL) begin
			rd_mux = {4'h0, st_q.lp_ctrl};
		end else if (avs_req.address == dco_pkg::ADDR_STATUS) begin
			rd_mux = {2'h0, status};
		end else begin
			rd_mux = 8'h00;
		end
	end

	always_comb begin
		st_d = st_q;
		// crystal pins: two-stage synchronisers
		st_d.lf_sync = {st_q.lf_sync[0], low_freq_xtal_clock};
		st_d.xt2_sync = {st_q.xt2_sync[0], second_xtal_clock};
		st_d.lf_prev = st_q.lf_sync[1];
		st_d.xt2_prev = st_q.xt2_sync[1];
		// bus: one wait cycle, read data latched at the edge that sets ack, write committed at the following edge
		st_d.ack = (avs_req.read || avs_req.write) && !st_q.ack;
		if ((avs_req.read || avs_req.write) && !st_q.ack) begin
			st_d.rdata = rd_mux;
		end
		if (avs_req.write && st_q.ack && avs_req.byteenable[0]) begin
			if (avs_req.address == dco_pkg::ADDR_DCO_CTRL) begin
				st_d.dco_ctrl = avs_req.writedata[7:0];
			end else if (avs_req.address == dco_pkg::ADDR_RES_CTRL) begin
				st_d.res_ctrl = avs_req.writedata[3:0];
			end else if (avs_req.address == dco_pkg::ADDR_CLK_CTRL) begin
				st_d.clk_ctrl = avs_req.writedata[7:0];
			end else if (avs_req.address == dco_pkg::ADDR_LP_CTRL) begin
				st_d.lp_ctrl = avs_req.writedata[3:0];
			end
		end
		// dc generator start-up after being switched off
		if (!bias_generator_on) begin
			st_d.bias_generator_ready = 1'b0;
			st_d.start_cnt = '0;
		end else if (!st_q.bias_generator_ready) begin
			if (st_q.start_cnt >= dco_pkg::BIAS_GENERATOR_START_LIM) begin
				st_d.bias_generator_ready = 1'b1;
			end else begin
				st_d.start_cnt = st_q.start_cnt + 8'h01;
			end
		end
		// oscillator model with 32-slot modulator frame
		if (!dco_run) begin
			st_d.per_cnt = '0;
		end else if (dco_tick) begin
			st_d.per_cnt = '0;
			st_d.dco_level = !st_q.dco_level;
			// cycle runs rise to rise: slot moves only on the rising edge
			if (!st_q.dco_level) begin
				st_d.slot = st_q.slot + 5'h01;
			end
		end else begin
			st_d.per_cnt = st_q.per_cnt + 6'h01;
		end
		if (power_up_clear) begin
			st_d.dco_ctrl = dco_pkg::DCO_CTRL_RESET;
			st_d.res_ctrl = dco_pkg::RES_CTRL_RESET;
			st_d.clk_ctrl = dco_pkg::CLK_CTRL_RESET;
			st_d.lp_ctrl = dco_pkg::LP_CTRL_RESET;
			st_d.slot = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '{dco_ctrl: dco_pkg::DCO_CTRL_RESET, res_ctrl: dco_pkg::RES_CTRL_RESET,
				clk_ctrl: dco_pkg::CLK_CTRL_RESET, lp_ctrl: dco_pkg::LP_CTRL_RESET, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	clk_gen u_mclk_gen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.src_tick(mclk_tick),
		.divider(st_q.clk_ctrl.main_divider),
		.off(st_q.lp_ctrl.mclk_off),
		.clk_out(mclk_q)
	);

	clk_gen u_sub_main_clock_gen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.src_tick(sub_main_clock_tick),
		.divider(st_q.clk_ctrl.sub_divider),
		.off(st_q.lp_ctrl.sub_main_clock_off),
		.clk_out(sub_main_clock_q)
	);

	assign clocks = '{dco: st_q.dco_level, mclk: mclk_q, sub_main_clock: sub_main_clock_q};
	assign avs_readdata = {24'h000000, st_q.rdata};
	assign avs_waitrequest = (avs_req.read || avs_req.write) && !st_q.ack;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_all_off;
		st_q.lp_ctrl.dco_generator_off && !mclk_need && !sub_main_clock_need |=> !st_q.bias_generator_ready;
	endproperty
	a_all_off: assert property (p_all_off) else $error("dc generator still ready when switched off");

	property p_sub_no_need;
		st_q.lp_ctrl.sub_main_clock_off || st_q.clk_ctrl.sub_main_clock_source_select |-> !sub_main_clock_need;
	endproperty
	a_sub_no_need: assert property (p_sub_no_need) else $error("sub clock demands dco wrongly");

	property p_main_no_need;
		st_q.lp_ctrl.mclk_off || st_q.clk_ctrl.mclk_source_select[1] |-> !mclk_need;
	endproperty
	a_main_no_need: assert property (p_main_no_need) else $error("main clock demands dco wrongly");

	property p_osc_stopped;
		!dco_enable |=> $stable(st_q.dco_level);
	endproperty
	a_osc_stopped: assert property (p_osc_stopped) else $error("dco toggled while disabled");

	property p_gen_forced;
		mclk_need || sub_main_clock_need |-> bias_generator_on;
	endproperty
	a_gen_forced: assert property (p_gen_forced) else $error("dc generator off while dco used");

	property p_puc_defaults;
		power_up_clear |=> st_q.dco_ctrl.freq_step_select == 3'h3 && st_q.dco_ctrl.fraction_count == 5'h00
			&& st_q.res_ctrl.resistor_select == 3'h4;
	endproperty
	a_puc_defaults: assert property (p_puc_defaults) else $error("power-up clear defaults wrong");

	property p_puc_sources;
		power_up_clear |=> st_q.clk_ctrl.mclk_source_select == 2'h0 && !st_q.clk_ctrl.sub_main_clock_source_select
			&& st_q.lp_ctrl == 4'h0;
	endproperty
	a_puc_sources: assert property (p_puc_sources) else $error("power-up clear left sources or low-power bits");

	property p_start_delay;
		$rose(bias_generator_on) |=> !st_q.bias_generator_ready [*8];
	endproperty
	a_start_delay: assert property (p_start_delay) else $error("dc generator ready without start-up delay");

	property p_no_mod;
		st_q.dco_ctrl.fraction_count == 5'h00 || st_q.dco_ctrl.freq_step_select == 3'h7 |-> !use_high;
	endproperty
	a_no_mod: assert property (p_no_mod) else $error("modulation applied when not allowed");

	property p_slot_on_rise;
		$rose(st_q.dco_level) && !$past(power_up_clear) |-> st_q.slot == 5'($past(st_q.slot) + 5'h01);
	endproperty
	a_slot_on_rise: assert property (p_slot_on_rise) else $error("slot not advanced on rise");

	property p_step_held;
		$fell(st_q.dco_level) && !$past(power_up_clear) |-> $stable(st_q.slot);
	endproperty
	a_step_held: assert property (p_step_held) else $error("slot changed within a cycle");

	property p_no_bias;
		st_q.res_ctrl.resistor_off && !st_q.clk_ctrl.external_resistor_select |=> $stable(st_q.dco_level);
	endproperty
	a_no_bias: assert property (p_no_bias) else $error("dco toggled without bias");

	property p_ready_kept;
		bias_generator_on && st_q.bias_generator_ready |=> st_q.bias_generator_ready;
	endproperty
	a_ready_kept: assert property (p_ready_kept) else $error("generator ready lost while on");
endmodule

// ===== shared/dco_pkg.sv
package dco_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int BIAS_GENERATOR_START_NS = 2000;
	localparam int BIAS_GENERATOR_START_CYC = (BIAS_GENERATOR_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] BIAS_GENERATOR_START_LIM = 8'(BIAS_GENERATOR_START_CYC - 1);
	// build: second crystal present
	localparam bit THREE_OSC = 1'b1;
	// oscillator model, half period in clk_sys cycles
	localparam logic [5:0] HALF_PERIOD_BASE = 6'h10;
	localparam logic [2:0] STEP_MAX = 3'h7;
	localparam logic [1:0] MSEL_XT2 = 2'h2;
	// register byte offsets
	localparam logic [4:0] ADDR_DCO_CTRL = 5'h00;
	localparam logic [4:0] ADDR_RES_CTRL = 5'h04;
	localparam logic [4:0] ADDR_CLK_CTRL = 5'h08;
	localparam logic [4:0] ADDR_LP_CTRL = 5'h0c;
	localparam logic [4:0] ADDR_STATUS = 5'h10;

	typedef struct packed {
		logic [4:0] fraction_count;
		logic [2:0] freq_step_select;
	} dco_ctrl_s;

	typedef struct packed {
		logic resistor_off;
		logic [2:0] resistor_select;
	} res_ctrl_s;

	typedef struct packed {
		logic [1:0] mclk_source_select;
		logic [1:0] main_divider;
		logic sub_main_clock_source_select;
		logic [1:0] sub_divider;
		logic external_resistor_select;
	} clk_ctrl_s;

	typedef struct packed {
		logic osc_off;
		logic sub_main_clock_off;
		logic dco_generator_off;
		logic mclk_off;
	} lp_ctrl_s;

	typedef struct packed {
		logic use_high_step;
		logic sub_main_clock;
		logic mclk;
		logic bias_generator_ready;
		logic bias_generator_on;
		logic dco_enable;
	} status_s;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} avs_req_s;

	typedef struct packed {
		logic dco;
		logic mclk;
		logic sub_main_clock;
	} sys_clocks_s;

	localparam dco_ctrl_s DCO_CTRL_RESET = '{fraction_count: 5'h00, freq_step_select: 3'h3};
	localparam res_ctrl_s RES_CTRL_RESET = '{resistor_off: 1'b0, resistor_select: 3'h4};
	localparam clk_ctrl_s CLK_CTRL_RESET = '0;
	localparam lp_ctrl_s LP_CTRL_RESET = '0;
endpackage

// ===== sim/clk_consumer.sv
module clk_consumer #(
	parameter int XT2_HALF = 5,
	parameter int LF_HALF = 9
) (
	// clock under observation
	input wire logic clk_sys,
	input wire dco_pkg::sys_clocks_s clocks,
	// crystal pins
	output logic low_freq_xtal_clock,
	output logic second_xtal_clock,
	// measured periods in clk_sys cycles: 0 sub_main_clock, 1 mclk, 2 dco
	output int period [3],
	output int rises [3]
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt [3];
	int xc [2];
	logic [2:0] prev;

	initial begin
		low_freq_xtal_clock = 1'b0;
		second_xtal_clock = 1'b0;
		prev = 3'h0;
		xc = '{0, 0};
		cnt = '{0, 0, 0};
		period = '{0, 0, 0};
		rises = '{0, 0, 0};
	end

	// free-running crystals at unrelated rates
	always @(posedge clk_sys) begin
		xc[0] <= (xc[0] == LF_HALF - 1) ? 0 : xc[0] + 1;
		xc[1] <= (xc[1] == XT2_HALF - 1) ? 0 : xc[1] + 1;
		if (xc[0] == LF_HALF - 1) low_freq_xtal_clock <= ~low_freq_xtal_clock;
		if (xc[1] == XT2_HALF - 1) second_xtal_clock <= ~second_xtal_clock;
		for (int i = 0; i < 3; i++) begin
			cnt[i] <= cnt[i] + 1;
			if (clocks[i] && !prev[i]) begin
				period[i] <= cnt[i] + 1;
				cnt[i] <= 0;
				rises[i] <= rises[i] + 1;
			end
		end
		prev <= clocks;
	end
endmodule

// ===== sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int XT2_HALF = 5;
	localparam int LF_HALF = 9;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic power_up_clear = 1'b0;
	dco_pkg::avs_req_s req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, dco_enable, bias_generator_on, bias_from_external, lf_clk, xt2_clk;
	logic [3:0] internal_resistor_value;
	dco_pkg::sys_clocks_s clocks;
	int period [3];
	int rises [3];
	int n_errors = 0;
	int comparisons = 0;
	int seed = 32'hc2b3;
	int sum, bad, t, st, fe;
	logic [7:0] rd, cc;
	logic [7:0] mod_t [5] = '{8'h03, 8'h0b, 8'h6b, 8'hfb, 8'h2f};
	logic [7:0] rv [6] = '{8'h03, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00};

	always #25 clk_sys = ~clk_sys;

	dco_clock_control_modulator u_dco_clock_control_modulator (.clk_sys(clk_sys), .rst_n(rst_n),
		.power_up_clear(power_up_clear), .low_freq_xtal_clock(lf_clk), .second_xtal_clock(xt2_clk),
		.avs_req(req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.dco_enable(dco_enable), .bias_generator_on(bias_generator_on), .internal_resistor_value(internal_resistor_value),
		.bias_from_external(bias_from_external), .clocks(clocks));
	clk_consumer #(.XT2_HALF(XT2_HALF), .LF_HALF(LF_HALF)) u_clk_consumer (.clk_sys(clk_sys),
		.clocks(clocks), .low_freq_xtal_clock(lf_clk), .second_xtal_clock(xt2_clk), .period(period),
		.rises(rises));

	function automatic int dco_half(input int rsel, input int step);
		return 16 + (7 - rsel) + (7 - step);
	endfunction

	// expected {bias_generator_on, dco_enable} from clock control and low-power bits
	function automatic logic [1:0] gen_exp(input logic [7:0] c, input logic [3:0] lp);
		logic need;
		need = (!lp[0] && !c[7]) || (!lp[2] && !c[3]);
		return {need || !lp[1], need};
	endfunction

	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: {24'h0, d}};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_errors++;
			test_done();
		end
		rd = avs_readdata[7:0];
		req <= '0;
	endtask

	task automatic wait_rises(input int i, input int k);
		int s;
		int n;
		s = rises[i];
		n = 0;
		while (rises[i] - s < k && n < 20000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20000) begin
			n_errors++;
			test_done();
		end
	endtask

	task automatic check_defaults;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00);
			chk("register default", rd, rv[i]);
		end
		chk("resistor value", internal_resistor_value, 4'h4);
		chk("enables", {bias_generator_on, dco_enable}, 2'h3);
	endtask

	task automatic restart_time;
		st = rises[2];
		t = 0;
		while (rises[2] == st && t < 500) begin
			@(posedge clk_sys);
			t++;
		end
		if (t >= 500) begin
			n_errors++;
			test_done();
		end
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		check_defaults();
		wait_rises(1, 2);
		chk("mclk from dco", period[1], 2 * dco_half(4, 3));
		for (int i = 0; i < 16; i++) begin
			cc = 8'($random(seed));
			bus(1'b1, dco_pkg::ADDR_CLK_CTRL, cc);
			bus(1'b1, dco_pkg::ADDR_LP_CTRL, {4'h0, 4'(i)});
			@(posedge clk_sys);
			chk("enables", {bias_generator_on, dco_enable}, gen_exp(cc, 4'(i)));
			chk("bias source", bias_from_external, cc[0]);
			bus(1'b0, dco_pkg::ADDR_CLK_CTRL, 8'h00);
			chk("clock control", rd, cc);
		end
		bus(1'b1, dco_pkg::ADDR_LP_CTRL, 8'h00);
		for (int d = 0; d < 4; d++) begin
			bus(1'b1, dco_pkg::ADDR_CLK_CTRL, {2'h0, 2'(d), 1'b0, 2'(d), 1'b0});
			wait_rises(1, 3);
			wait_rises(0, 2);
			chk("mclk divided", period[1], (2 * dco_half(4, 3)) << d);
			chk("sub_main_clock divided", period[0], (2 * dco_half(4, 3)) << d);
		end
		for (int m = 1; m < 4; m++) begin
			bus(1'b1, dco_pkg::ADDR_CLK_CTRL, {2'(m), 2'h1, 1'b1, 2'h0, 1'b0});
			wait_rises(1, 3);
			wait_rises(0, 3);
			chk("mclk source", period[1], 4 * ((m == 1) ? dco_half(4, 3) : (m == 2) ? XT2_HALF : LF_HALF));
			chk("sub_main_clock source", period[0], 2 * XT2_HALF);
		end
		bus(1'b1, dco_pkg::ADDR_CLK_CTRL, 8'h00);
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, dco_pkg::ADDR_DCO_CTRL, mod_t[k]);
			fe = (mod_t[k][2:0] == 3'h7) ? 0 : int'(mod_t[k][7:3]);
			wait_rises(2, 2);
			sum = 0;
			bad = 0;
			repeat (32) begin
				wait_rises(2, 1);
				sum += period[2];
				if (period[2] != 2 * dco_half(4, mod_t[k][2:0]) && period[2] != 2 * dco_half(4, mod_t[k][2:0] + 1)) bad++;
			end
			chk("frame length", sum, (32 - fe) * 2 * dco_half(4, mod_t[k][2:0]) + fe * 2 * dco_half(4, mod_t[k][2:0] + 1));
			chk("cycle period", bad, 0);
		end
		bus(1'b1, dco_pkg::ADDR_DCO_CTRL, 8'h03);
		bus(1'b1, dco_pkg::ADDR_RES_CTRL, 8'h02);
		wait_rises(2, 3);
		chk("resistor period", period[2], 2 * dco_half(2, 3));
		bus(1'b1, dco_pkg::ADDR_RES_CTRL, 8'h0a);
		@(posedge clk_sys);
		chk("resistor value", internal_resistor_value, 4'ha);
		bus(1'b1, dco_pkg::ADDR_RES_CTRL, 8'h04);
		for (int g = 0; g < 2; g++) begin
			bus(1'b1, dco_pkg::ADDR_LP_CTRL, (g == 0) ? 8'h01 : 8'h04);
			repeat (100) @(posedge clk_sys);
			bad = 0;
			repeat (200) begin
				@(posedge clk_sys);
				if (((g == 0) ? clocks.mclk : clocks.sub_main_clock) !== 1'b0) bad++;
			end
			chk("gated clock", bad, 0);
		end
		bus(1'b1, dco_pkg::ADDR_LP_CTRL, 8'h07);
		repeat (20) @(posedge clk_sys);
		bus(1'b1, dco_pkg::ADDR_LP_CTRL, 8'h06);
		restart_time();
		chk("slow restart", t >= dco_pkg::BIAS_GENERATOR_START_CYC + dco_half(4, 3), 1'b1);
		bus(1'b1, dco_pkg::ADDR_LP_CTRL, 8'h05);
		repeat (20) @(posedge clk_sys);
		bus(1'b1, dco_pkg::ADDR_LP_CTRL, 8'h00);
		restart_time();
		chk("fast restart", t <= 2 * dco_half(4, 3) + 2, 1'b1);
		bus(1'b1, dco_pkg::ADDR_DCO_CTRL, 8'hfe);
		bus(1'b1, dco_pkg::ADDR_RES_CTRL, 8'h01);
		bus(1'b1, dco_pkg::ADDR_CLK_CTRL, 8'hc8);
		bus(1'b1, dco_pkg::ADDR_LP_CTRL, 8'h0f);
		power_up_clear <= 1'b1;
		repeat (2) @(posedge clk_sys);
		power_up_clear <= 1'b0;
		check_defaults();
		test_done();
	end
endmodule
